/* aoc_defines.vh */
// Register map, field positions, reset values and timing of the audio output controls
`ifndef AOC_DEFINES_VH
`define AOC_DEFINES_VH
`define AOC_OFS_OUT_EN 16'h0D08
`define AOC_OFS_MUTE 16'h0D0A
`define AOC_OFS_SHORT 16'h0D0B
`define AOC_OFS_PUMP 16'h0D0C
`define AOC_OFS_ENV_THR 16'h0D0D
`define AOC_OFS_ENV_DEC 16'h0D0E
`define AOC_OFS_PWM_RT 16'h0D0F
`define AOC_OFS_V1P 16'h0D10
`define AOC_OFS_V1N 16'h0D11
`define AOC_OFS_V2P 16'h0D12
`define AOC_OFS_V2N 16'h0D13
`define AOC_OFS_STATUS 16'h0D20
`define AOC_OFS_GAIN 16'h0D21
`define AOC_RST_ZERO 8'h00
`define AOC_RST_MUTE 8'h77
`define AOC_RST_PWM 8'h32
`define AOC_OE_EAR 6
`define AOC_OE_HSL 5
`define AOC_OE_HSR 4
`define AOC_OE_HFL 3
`define AOC_OE_HFR 2
`define AOC_OE_VIB1 1
`define AOC_OE_VIB2 0
`define AOC_SC_AUTO_OFF 7
`define AOC_SC_EAR_DIS 6
`define AOC_SC_HS_DIS 5
`define AOC_SC_PULLDN 4
`define AOC_SC_OSC 2
`define AOC_SC_FADE_OFF 1
`define AOC_SC_ZC_OFF 0
`define AOC_PC_PUMP_EN 7
`define AOC_PC_LO_L_SRC 5
`define AOC_PC_LO_R_SRC 4
`define AOC_PC_LO_L_ON 3
`define AOC_PC_LO_R_ON 2
`define AOC_PC_AUTO 0
`define AOC_TH_HI_LSB 4
`define AOC_ED_SUPPLY 5
`define AOC_ED_ENV_ON 4
`define AOC_PR_SRC1 7
`define AOC_PR_SRC2 6
`define AOC_PR_DIFF1 5
`define AOC_PR_DIFF2 4
`define AOC_PR_1N 3
`define AOC_PR_1P 2
`define AOC_PR_2N 1
`define AOC_PR_2P 0
`define AOC_PW_LEVEL 7
`define AOC_ST_SHORT_EAR 1
`define AOC_ST_SHORT_HS 2
`define AOC_CLK_MHZ 250
`define AOC_DECAY_BASE_NS 26600
`define AOC_FADE_STEP_US 2000
`define AOC_ZC_TIMEOUT_US 100
`define AOC_DRV_OFF_NS 1000
`define AOC_PWM_PERIOD 7'd100
`define AOC_DUTY_FULL 7'd100
`define AOC_THR_BASE_MV 10'd25
`define AOC_THR_STEP_MV 10'd50
`endif

/* aoc_hs_seq.v */
// Headset driver and negative charge pump start-up and shutdown sequencer
`timescale 1ns/100ps
`include "aoc_defines.vh"
module aoc_hs_seq #(
    parameter OFF_CYC = `AOC_DRV_OFF_NS * `AOC_CLK_MHZ / 1000
) (
    input wire clock_i,
    input wire nrst_i,
    input wire auto_i,
    input wire pump_en_i,
    input wire hs_l_en_i,
    input wire hs_r_en_i,
    input wire pump_valid_i,
    input wire trip_i,
    output reg pump_on_o,
    output reg drv_l_o,
    output reg drv_r_o
);
    localparam S_OFF = 2'd0;
    localparam S_RAMP = 2'd1;
    localparam S_ON = 2'd2;
    localparam S_DOWN = 2'd3;
    localparam integer OFF_LAST_I = OFF_CYC - 1;
    localparam [15:0] OFF_LAST = OFF_LAST_I[15:0];
    reg [1:0] state_q;
    reg [15:0] cnt_q;
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            state_q <= S_OFF;
            cnt_q <= 16'h0000;
            pump_on_o <= 1'b0;
            drv_l_o <= 1'b0;
            drv_r_o <= 1'b0;
        end else if (!auto_i) begin
            state_q <= S_OFF;
            cnt_q <= 16'h0000;
            pump_on_o <= pump_en_i;
            drv_l_o <= hs_l_en_i & ~trip_i;
            drv_r_o <= hs_r_en_i & ~trip_i;
        end else begin
            case (state_q)
                S_OFF: begin
                    drv_l_o <= 1'b0;
                    drv_r_o <= 1'b0;
                    if (pump_en_i) begin
                        pump_on_o <= 1'b1;
                        state_q <= S_RAMP;
                    end
                end
                S_RAMP: begin
                    if (!pump_en_i) begin
                        cnt_q <= 16'h0000;
                        state_q <= S_DOWN;
                    end else if (pump_valid_i) begin
                        state_q <= S_ON;
                    end
                end
                S_ON: begin
                    if (!pump_en_i) begin
                        drv_l_o <= 1'b0;
                        drv_r_o <= 1'b0;
                        cnt_q <= 16'h0000;
                        state_q <= S_DOWN;
                    end else begin
                        drv_l_o <= hs_l_en_i & ~trip_i;
                        drv_r_o <= hs_r_en_i & ~trip_i;
                    end
                end
                S_DOWN: begin
                    drv_l_o <= 1'b0;
                    drv_r_o <= 1'b0;
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q >= OFF_LAST) begin
                        pump_on_o <= 1'b0;
                        state_q <= S_OFF;
                    end
                end
                default: begin
                    state_q <= S_OFF;
                end
            endcase
        end
    end
endmodule

/* aoc_output_ctrl.v */
// Audio output stage control registers, headset gain, envelope and vibrator PWM
`timescale 1ns/100ps
`include "aoc_defines.vh"
module aoc_output_ctrl #(
    parameter FADE_CYC = `AOC_FADE_STEP_US * `AOC_CLK_MHZ,
    parameter ZC_CYC = `AOC_ZC_TIMEOUT_US * `AOC_CLK_MHZ,
    parameter DECAY_CYC = `AOC_DECAY_BASE_NS * `AOC_CLK_MHZ / 1000
) (
    input wire clock_i,
    input wire nrst_i,
    input wire [15:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire pump_output_valid_i,
    input wire ear_short_i,
    input wire hs_short_i,
    input wire zero_cross_i,
    input wire [3:0] hs_gain_target_i,
    input wire [9:0] dac_mag_i,
    output reg [5:0] silence_o,
    output reg ear_short_detect_on_o,
    output reg hs_short_detect_on_o,
    output reg headset_pulldown_select_o,
    output reg headset_local_osc_select_o,
    output reg [3:0] hs_gain_o,
    output reg left_lineout_src_sel_o,
    output reg right_lineout_src_sel_o,
    output reg left_lineout_on_o,
    output reg right_lineout_on_o,
    output reg ear_drv_on_o,
    output reg left_handsfree_drv_on_o,
    output reg right_handsfree_drv_on_o,
    output reg vib_one_drv_on_o,
    output reg vib_two_drv_on_o,
    output wire neg_pump_on_o,
    output wire left_headset_drv_on_o,
    output wire right_headset_drv_on_o,
    output reg pump_low_voltage_o,
    output reg pump_supply_select_o,
    output reg vib_one_pwm_source_o,
    output reg vib_two_pwm_source_o,
    output wire [3:0] vib_pwm_o
);
    reg [7:0] out_en_q;
    reg [7:0] mute_q;
    reg [7:0] short_q;
    reg [7:0] pump_q;
    reg [7:0] env_thr_q;
    reg [7:0] env_dec_q;
    reg [7:0] pwm_rt_q;
    reg [7:0] pwm_q [0:3];
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    reg trip_ear_q;
    reg trip_hs_q;
    wire valid_s;
    wire ear_short_s;
    wire hs_short_s;
    wire wr_stat;
    wire ear_evt;
    wire hs_evt;
    integer i;

    // Two-stage synchronisers for the analog status pins
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            sync1_q <= 3'b000;
            sync2_q <= 3'b000;
        end else begin
            sync1_q <= {hs_short_i, ear_short_i, pump_output_valid_i};
            sync2_q <= sync1_q;
        end
    end
    assign valid_s = sync2_q[0];
    assign ear_short_s = sync2_q[1];
    assign hs_short_s = sync2_q[2];

    // Register writes
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            out_en_q <= `AOC_RST_ZERO;
            mute_q <= `AOC_RST_MUTE;
            short_q <= `AOC_RST_ZERO;
            pump_q <= `AOC_RST_ZERO;
            env_thr_q <= `AOC_RST_ZERO;
            env_dec_q <= `AOC_RST_ZERO;
            pwm_rt_q <= `AOC_RST_ZERO;
            for (i = 0; i < 4; i = i + 1) begin
                pwm_q[i] <= `AOC_RST_PWM;
            end
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `AOC_OFS_OUT_EN: out_en_q <= reg_wdata_i;
                `AOC_OFS_MUTE: mute_q <= reg_wdata_i & 8'h77;
                `AOC_OFS_SHORT: short_q <= reg_wdata_i & 8'hF7;
                `AOC_OFS_PUMP: pump_q <= reg_wdata_i & 8'hBD;
                `AOC_OFS_ENV_THR: env_thr_q <= reg_wdata_i;
                `AOC_OFS_ENV_DEC: env_dec_q <= reg_wdata_i & 8'h3F;
                `AOC_OFS_PWM_RT: pwm_rt_q <= reg_wdata_i;
                `AOC_OFS_V1P: pwm_q[0] <= reg_wdata_i;
                `AOC_OFS_V1N: pwm_q[1] <= reg_wdata_i;
                `AOC_OFS_V2P: pwm_q[2] <= reg_wdata_i;
                `AOC_OFS_V2N: pwm_q[3] <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Short trips latch until software writes one to the status bit; a short still present in that cycle keeps the trip set
    assign wr_stat = reg_wr_i && (reg_addr_i == `AOC_OFS_STATUS);
    assign ear_evt = ear_short_s & ~short_q[`AOC_SC_EAR_DIS];
    assign hs_evt = hs_short_s & ~short_q[`AOC_SC_HS_DIS];
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            trip_ear_q <= 1'b0;
            trip_hs_q <= 1'b0;
        end else begin
            if (ear_evt && short_q[`AOC_SC_AUTO_OFF]) begin
                trip_ear_q <= 1'b1;
            end else if (wr_stat && reg_wdata_i[`AOC_ST_SHORT_EAR]) begin
                trip_ear_q <= 1'b0;
            end
            if (hs_evt && short_q[`AOC_SC_AUTO_OFF]) begin
                trip_hs_q <= 1'b1;
            end else if (wr_stat && reg_wdata_i[`AOC_ST_SHORT_HS]) begin
                trip_hs_q <= 1'b0;
            end
        end
    end

    // Headset driver and pump sequencing
    aoc_hs_seq u_seq (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .auto_i(pump_q[`AOC_PC_AUTO]),
        .pump_en_i(pump_q[`AOC_PC_PUMP_EN]),
        .hs_l_en_i(out_en_q[`AOC_OE_HSL]),
        .hs_r_en_i(out_en_q[`AOC_OE_HSR]),
        .pump_valid_i(valid_s),
        .trip_i(trip_hs_q),
        .pump_on_o(neg_pump_on_o),
        .drv_l_o(left_headset_drv_on_o),
        .drv_r_o(right_headset_drv_on_o)
    );

    // Static control outputs
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            silence_o <= 6'h3F;
            ear_short_detect_on_o <= 1'b0;
            hs_short_detect_on_o <= 1'b0;
            headset_pulldown_select_o <= 1'b0;
            headset_local_osc_select_o <= 1'b0;
            left_lineout_src_sel_o <= 1'b0;
            right_lineout_src_sel_o <= 1'b0;
            left_lineout_on_o <= 1'b0;
            right_lineout_on_o <= 1'b0;
            ear_drv_on_o <= 1'b0;
            left_handsfree_drv_on_o <= 1'b0;
            right_handsfree_drv_on_o <= 1'b0;
            vib_one_drv_on_o <= 1'b0;
            vib_two_drv_on_o <= 1'b0;
            vib_one_pwm_source_o <= 1'b0;
            vib_two_pwm_source_o <= 1'b0;
        end else begin
            silence_o <= {mute_q[6:4], mute_q[2:0]};
            ear_short_detect_on_o <= ~short_q[`AOC_SC_EAR_DIS];
            hs_short_detect_on_o <= ~short_q[`AOC_SC_HS_DIS];
            headset_pulldown_select_o <= short_q[`AOC_SC_PULLDN];
            headset_local_osc_select_o <= short_q[`AOC_SC_OSC];
            left_lineout_src_sel_o <= pump_q[`AOC_PC_LO_L_SRC];
            right_lineout_src_sel_o <= pump_q[`AOC_PC_LO_R_SRC];
            left_lineout_on_o <= pump_q[`AOC_PC_LO_L_ON] & ~out_en_q[`AOC_OE_HFL];
            right_lineout_on_o <= pump_q[`AOC_PC_LO_R_ON] & ~out_en_q[`AOC_OE_HFR];
            ear_drv_on_o <= out_en_q[`AOC_OE_EAR] & ~trip_ear_q;
            left_handsfree_drv_on_o <= out_en_q[`AOC_OE_HFL];
            right_handsfree_drv_on_o <= out_en_q[`AOC_OE_HFR];
            vib_one_drv_on_o <= out_en_q[`AOC_OE_VIB1];
            vib_two_drv_on_o <= out_en_q[`AOC_OE_VIB2];
            vib_one_pwm_source_o <= pwm_rt_q[`AOC_PR_SRC1];
            vib_two_pwm_source_o <= pwm_rt_q[`AOC_PR_SRC2];
        end
    end

    // Headset gain fading and zero-cross gating
    reg [31:0] fade_cnt_q;
    reg [31:0] zc_cnt_q;
    reg ready_q;
    wire pend;
    wire fade_off;
    wire apply;
    assign pend = (hs_gain_o != hs_gain_target_i);
    assign fade_off = short_q[`AOC_SC_FADE_OFF];
    assign apply = ready_q && pend && (short_q[`AOC_SC_ZC_OFF] || zero_cross_i
                   || (zc_cnt_q >= ZC_CYC - 1));
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            hs_gain_o <= 4'h0;
            fade_cnt_q <= 32'h00000000;
            zc_cnt_q <= 32'h00000000;
            ready_q <= 1'b0;
        end else if (!pend) begin
            fade_cnt_q <= 32'h00000000;
            zc_cnt_q <= 32'h00000000;
            ready_q <= 1'b0;
        end else if (apply) begin
            ready_q <= 1'b0;
            fade_cnt_q <= 32'h00000000;
            zc_cnt_q <= 32'h00000000;
            if (fade_off) begin
                hs_gain_o <= hs_gain_target_i;
            end else if (hs_gain_o < hs_gain_target_i) begin
                hs_gain_o <= hs_gain_o + 4'h1;
            end else begin
                hs_gain_o <= hs_gain_o - 4'h1;
            end
        end else if (ready_q) begin
            zc_cnt_q <= zc_cnt_q + 32'h00000001;
        end else if (fade_off || fade_cnt_q >= FADE_CYC - 1) begin
            ready_q <= 1'b1;
        end else begin
            fade_cnt_q <= fade_cnt_q + 32'h00000001;
        end
    end

    // Envelope detector on the digital DAC path magnitude
    function [9:0] thr_mv;
        input [3:0] code;
        begin
            if (code == 4'h0) begin
                thr_mv = `AOC_THR_BASE_MV;
            end else begin
                thr_mv = `AOC_THR_STEP_MV * {6'h00, code};
            end
        end
    endfunction
    reg [9:0] env_q;
    reg [27:0] dec_cnt_q;
    wire [31:0] dec_lim_w;
    wire env_on;
    assign dec_lim_w = DECAY_CYC << env_dec_q[3:0];
    assign env_on = env_dec_q[`AOC_ED_ENV_ON];
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            env_q <= 10'h000;
            dec_cnt_q <= 28'h0000000;
            pump_low_voltage_o <= 1'b0;
            pump_supply_select_o <= 1'b0;
        end else begin
            if (!env_on) begin
                env_q <= 10'h000;
                dec_cnt_q <= 28'h0000000;
            end else if ({4'h0, dec_cnt_q} >= dec_lim_w - 32'h00000001) begin
                env_q <= dac_mag_i;
                dec_cnt_q <= 28'h0000000;
            end else begin
                dec_cnt_q <= dec_cnt_q + 28'h0000001;
                if (dac_mag_i > env_q) begin
                    env_q <= dac_mag_i;
                end
            end
            pump_low_voltage_o <= env_on
                && (env_q < thr_mv(env_thr_q[7:`AOC_TH_HI_LSB]));
            if (env_on) begin
                pump_supply_select_o <= (env_q >= thr_mv(env_thr_q[3:0]));
            end else begin
                pump_supply_select_o <= env_dec_q[`AOC_ED_SUPPLY];
            end
        end
    end

    // Two PWM period counters, restarted when their vibrator takes the generator
    reg [6:0] cnt_q [0:1];
    wire [1:0] run;
    wire [1:0] wrap;
    wire [3:0] use_duty;
    wire [3:0] ch_level;
    wire [27:0] ch_duty;
    assign run = {pwm_rt_q[`AOC_PR_SRC2], pwm_rt_q[`AOC_PR_SRC1]};
    assign use_duty[0] = pwm_rt_q[`AOC_PR_DIFF1] | pwm_rt_q[`AOC_PR_1P];
    assign use_duty[1] = pwm_rt_q[`AOC_PR_DIFF1] | pwm_rt_q[`AOC_PR_1N];
    assign use_duty[2] = pwm_rt_q[`AOC_PR_DIFF2] | pwm_rt_q[`AOC_PR_2P];
    assign use_duty[3] = pwm_rt_q[`AOC_PR_DIFF2] | pwm_rt_q[`AOC_PR_2N];
    assign ch_level = {pwm_q[3][`AOC_PW_LEVEL], pwm_q[2][`AOC_PW_LEVEL],
                       pwm_q[1][`AOC_PW_LEVEL], pwm_q[0][`AOC_PW_LEVEL]};
    assign ch_duty[6:0] = pwm_q[0][6:0];
    assign ch_duty[13:7] = pwm_q[1][6:0];
    // Differential second generator drives both outputs from the negative duty
    assign ch_duty[20:14] = pwm_rt_q[`AOC_PR_DIFF2] ? pwm_q[3][6:0] : pwm_q[2][6:0];
    assign ch_duty[27:21] = pwm_q[3][6:0];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_cnt
            assign wrap[g] = (cnt_q[g] == `AOC_PWM_PERIOD - 7'd1);
            always @(posedge clock_i) begin
                if (!nrst_i || !run[g]) begin
                    cnt_q[g] <= 7'h00;
                end else if (wrap[g]) begin
                    cnt_q[g] <= 7'h00;
                end else begin
                    cnt_q[g] <= cnt_q[g] + 7'h01;
                end
            end
        end
        for (g = 0; g < 4; g = g + 1) begin : gen_ch
            aoc_pwm_ch u_ch (
                .clock_i(clock_i),
                .nrst_i(nrst_i),
                .run_i(run[g / 2]),
                .wrap_i(wrap[g / 2]),
                .cnt_i(cnt_q[g / 2]),
                .use_duty_i(use_duty[g]),
                .level_i(ch_level[g]),
                .duty_i(ch_duty[g * 7 +: 7]),
                .out_o(vib_pwm_o[g])
            );
        end
    endgenerate

    // Read data, one cycle after the read strobe; unmapped reads give zero
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `AOC_OFS_OUT_EN: reg_rdata_o <= out_en_q;
                `AOC_OFS_MUTE: reg_rdata_o <= mute_q;
                `AOC_OFS_SHORT: reg_rdata_o <= short_q;
                `AOC_OFS_PUMP: reg_rdata_o <= pump_q;
                `AOC_OFS_ENV_THR: reg_rdata_o <= env_thr_q;
                `AOC_OFS_ENV_DEC: reg_rdata_o <= env_dec_q;
                `AOC_OFS_PWM_RT: reg_rdata_o <= pwm_rt_q;
                `AOC_OFS_V1P: reg_rdata_o <= pwm_q[0];
                `AOC_OFS_V1N: reg_rdata_o <= pwm_q[1];
                `AOC_OFS_V2P: reg_rdata_o <= pwm_q[2];
                `AOC_OFS_V2N: reg_rdata_o <= pwm_q[3];
                `AOC_OFS_STATUS: reg_rdata_o <= {2'b00, right_headset_drv_on_o,
                    left_headset_drv_on_o, neg_pump_on_o, trip_hs_q, trip_ear_q, valid_s};
                `AOC_OFS_GAIN: reg_rdata_o <= {hs_gain_target_i, hs_gain_o};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule

/* aoc_output_ctrl_properties.sv */
// Port assertions for the audio output control block
`timescale 1ns/100ps
module aoc_chk (
    input wire clock_i,
    input wire nrst_i,
    input wire [15:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire [5:0] silence_o,
    input wire ear_short_detect_on_o,
    input wire hs_short_detect_on_o,
    input wire headset_pulldown_select_o,
    input wire headset_local_osc_select_o,
    input wire left_lineout_src_sel_o,
    input wire right_lineout_src_sel_o,
    input wire left_lineout_on_o,
    input wire right_lineout_on_o,
    input wire left_handsfree_drv_on_o,
    input wire right_handsfree_drv_on_o,
    input wire vib_one_drv_on_o,
    input wire vib_two_drv_on_o,
    input wire vib_one_pwm_source_o,
    input wire vib_two_pwm_source_o,
    input wire [3:0] vib_pwm_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire [7:0] w = reg_wdata_i;
    wire [15:0] a = reg_addr_i;
    property p_mute; reg_wr_i && a == 16'h0D0A |-> ##2
        silence_o == {$past(w[6:4], 2), $past(w[2:0], 2)}; endproperty
    property p_short; reg_wr_i && a == 16'h0D0B |-> ##2 {ear_short_detect_on_o,
        hs_short_detect_on_o, headset_pulldown_select_o, headset_local_osc_select_o}
        == {~$past(w[6:5], 2), $past(w[4], 2), $past(w[2], 2)}; endproperty
    property p_src; reg_wr_i && a == 16'h0D0C |-> ##2
        {left_lineout_src_sel_o, right_lineout_src_sel_o} == $past(w[5:4], 2); endproperty
    property p_lol; left_lineout_on_o |-> !left_handsfree_drv_on_o; endproperty
    property p_lor; right_lineout_on_o |-> !right_handsfree_drv_on_o; endproperty
    property p_vsrc; reg_wr_i && a == 16'h0D0F |-> ##2
        {vib_one_pwm_source_o, vib_two_pwm_source_o} == $past(w[7:6], 2); endproperty
    property p_oen; reg_wr_i && a == 16'h0D08 |-> ##2 {left_handsfree_drv_on_o,
        right_handsfree_drv_on_o, vib_one_drv_on_o, vib_two_drv_on_o} == $past(w[3:0], 2);
    endproperty
    property p_stop; !vib_one_pwm_source_o [*2] |-> vib_pwm_o[1:0] == 2'b00; endproperty
    a_mute: assert property (p_mute) else $error("mute outputs wrong");
    a_short: assert property (p_short) else $error("short config wrong");
    a_src: assert property (p_src) else $error("lineout source wrong");
    a_lol: assert property (p_lol) else $error("left lineout on with hf");
    a_lor: assert property (p_lor) else $error("right lineout on with hf");
    a_vsrc: assert property (p_vsrc) else $error("vib source wrong");
    a_oen: assert property (p_oen) else $error("output enables wrong");
    a_stop: assert property (p_stop) else $error("stopped pwm not low");
    c_mute: cover property (reg_wr_i && a == 16'h0D0A);
    c_lo: cover property (left_lineout_on_o);
    c_pwm: cover property ($rose(vib_pwm_o[0]));
endmodule
bind aoc_output_ctrl aoc_chk u_aoc_chk (.*);

/* aoc_pwm_ch.v */
// One PWM output channel with period-aligned update of its settings
`timescale 1ns/100ps
`include "aoc_defines.vh"
module aoc_pwm_ch (
    input wire clock_i,
    input wire nrst_i,
    input wire run_i,
    input wire wrap_i,
    input wire [6:0] cnt_i,
    input wire use_duty_i,
    input wire level_i,
    input wire [6:0] duty_i,
    output reg out_o
);
    reg use_q;
    reg level_q;
    reg [6:0] duty_q;
    wire hi;
    // Codes of 100 and above keep the output high all period
    assign hi = (duty_q >= `AOC_DUTY_FULL) || (cnt_i < duty_q);
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            use_q <= 1'b0;
            level_q <= 1'b0;
            duty_q <= 7'h00;
            out_o <= 1'b0;
        end else begin
            if (!run_i || wrap_i) begin
                use_q <= use_duty_i;
                level_q <= level_i;
                duty_q <= duty_i;
            end
            if (!run_i) begin
                out_o <= 1'b0;
            end else if (use_q) begin
                out_o <= hi;
            end else begin
                out_o <= level_q;
            end
        end
    end
endmodule

/* testbench.sv */
// Self-checking bench for the audio output control block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic clock_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, pump_output_valid_i = 0;
    logic ear_short_i = 0, hs_short_i = 0, zero_cross_i = 0;
    logic [15:0] reg_addr_i = 0;
    logic [7:0] reg_wdata_i = 0, reg_rdata_o;
    logic [3:0] hs_gain_target_i = 0, hs_gain_o, vib_pwm_o;
    logic [9:0] dac_mag_i = 0;
    logic [5:0] silence_o;
    logic ear_short_detect_on_o, hs_short_detect_on_o, headset_pulldown_select_o;
    logic headset_local_osc_select_o, left_lineout_src_sel_o, right_lineout_src_sel_o;
    logic left_lineout_on_o, right_lineout_on_o, ear_drv_on_o, left_handsfree_drv_on_o;
    logic right_handsfree_drv_on_o, vib_one_drv_on_o, vib_two_drv_on_o, neg_pump_on_o;
    logic left_headset_drv_on_o, right_headset_drv_on_o, pump_low_voltage_o;
    logic pump_supply_select_o, vib_one_pwm_source_o, vib_two_pwm_source_o;
    int n_mismatch = 0, n_tests = 0;
    always #2 clock_i = ~clock_i;
    aoc_output_ctrl #(.FADE_CYC(8), .ZC_CYC(5), .DECAY_CYC(4)) u_aoc_output_ctrl (.*);
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input [15:0] a, input [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input [15:0] a, input [7:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, e)
    endtask
    task automatic hi(input int b, input int e);
        int n;
        n = 0;
        wt(200);
        repeat (100) begin
            wt(1);
            n += (vib_pwm_o[b] === 1'b1);
        end
        `CHK(n, e)
    endtask
    task automatic gn(input [3:0] t, input z, input int n, input [3:0] e);
        @(posedge clock_i);
        hs_gain_target_i <= t;
        zero_cross_i <= z;
        wt(n);
        `CHK(hs_gain_o, e)
    endtask
    task final_report;
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        #1 `CHK(silence_o, 6'h3F)
        for (int k = 0; k < 9; k++) rd(16'h0D0A + k, k == 0 ? 8'h77 : k > 5 ? 8'h32 : 8'h00);
        rd(16'h0D30, 8'h00);
        wr(16'h0D0A, 8'h40);
        wt(2);
        `CHK(silence_o, 6'h20)
        wr(16'h0D0B, 8'hFF);
        rd(16'h0D0B, 8'hF7);
        `CHK({ear_short_detect_on_o, hs_short_detect_on_o, headset_pulldown_select_o, headset_local_osc_select_o}, 4'b0011)
        wr(16'h0D0B, 8'h00);
        wr(16'h0D0C, 8'h3C);
        wr(16'h0D08, 8'h08);
        wt(2);
        `CHK({left_lineout_src_sel_o, right_lineout_src_sel_o, left_lineout_on_o, right_lineout_on_o}, 4'b1101)
        wr(16'h0D0C, 8'h01);
        wr(16'h0D08, 8'h30);
        wr(16'h0D0C, 8'h81);
        wt(10);
        `CHK({neg_pump_on_o, left_headset_drv_on_o, right_headset_drv_on_o}, 3'b100)
        pump_output_valid_i <= 1'b1;
        wt(6);
        `CHK({neg_pump_on_o, left_headset_drv_on_o, right_headset_drv_on_o}, 3'b111)
        wr(16'h0D0C, 8'h01);
        wt(2);
        `CHK({neg_pump_on_o, left_headset_drv_on_o, right_headset_drv_on_o}, 3'b100)
        wt(200);
        `CHK(neg_pump_on_o, 1'b1)
        wt(60);
        `CHK(neg_pump_on_o, 1'b0)
        pump_output_valid_i <= 1'b0;
        wr(16'h0D08, 8'h00);
        wr(16'h0D0C, 8'h00);
        wr(16'h0D10, 8'h0A);
        wr(16'h0D0F, 8'h84);
        hi(0, 10);
        wr(16'h0D10, 8'h63);
        hi(0, 99);
        wr(16'h0D10, 8'h7F);
        hi(0, 100);
        wr(16'h0D0F, 8'h80);
        wr(16'h0D10, 8'h80);
        hi(0, 100);
        wr(16'h0D11, 8'h05);
        wr(16'h0D10, 8'h0F);
        wr(16'h0D0F, 8'hA0);
        hi(1, 5);
        hi(0, 15);
        wr(16'h0D13, 8'h14);
        wr(16'h0D0F, 8'h50);
        hi(3, 20);
        hi(2, 20);
        wr(16'h0D0F, 8'h00);
        wt(3);
        `CHK(vib_pwm_o, 4'h0)
        wr(16'h0D0B, 8'h03);
        gn(4'h9, 1'b0, 3, 4'h9);
        wr(16'h0D0B, 8'h02);
        gn(4'hA, 1'b0, 3, 4'h9);
        wt(4);
        `CHK(hs_gain_o, 4'hA)
        gn(4'h9, 1'b1, 3, 4'h9);
        wr(16'h0D0B, 8'h00);
        gn(4'hB, 1'b0, 16, 4'hA);
        wt(12);
        `CHK(hs_gain_o, 4'hB)
        wr(16'h0D08, 8'h40);
        ear_short_i <= 1'b1;
        wt(5);
        `CHK(ear_drv_on_o, 1'b1)
        wr(16'h0D0B, 8'hC0);
        wt(3);
        `CHK(ear_drv_on_o, 1'b1)
        wr(16'h0D0B, 8'h80);
        wt(3);
        `CHK(ear_drv_on_o, 1'b0)
        rd(16'h0D20, 8'h02);
        ear_short_i <= 1'b0;
        wt(3);
        wr(16'h0D20, 8'h02);
        wt(2);
        `CHK(ear_drv_on_o, 1'b1)
        wr(16'h0D0E, 8'h20);
        wt(2);
        `CHK({pump_low_voltage_o, pump_supply_select_o}, 2'b01)
        dac_mag_i <= 10'd60;
        wr(16'h0D0D, 8'h21);
        wr(16'h0D0E, 8'h30);
        wt(8);
        `CHK({pump_low_voltage_o, pump_supply_select_o}, 2'b11)
        dac_mag_i <= 10'd30;
        wt(12);
        `CHK({pump_low_voltage_o, pump_supply_select_o}, 2'b10)
        dac_mag_i <= 10'd120;
        wt(4);
        `CHK({pump_low_voltage_o, pump_supply_select_o}, 2'b01)
        final_report;
    end
endmodule
